/* rtl/arc_consts.vh */
// Operation
// - word-length option set makes the result register 16 bits, else 24 bits.
// - changing word length never re-rounds a held result; next new result uses it.
// - checksum is 24-bit XOR of user registers and internal trim bits; the interface mode register is left out.
// - checksum register reads zero unless the integrity check enable is set.
// - result is offset binary unless the active setup selects unipolar coding.
// - any result register read drives ready bit and pin ready high.
// - the same result may be read repeatedly.
// - a new result is held off while the result register is being read.
// - status-append option adds the status byte after the result on reads.
// - bit 14 turns on the power-down switch sink; reset clear.
// - bit 13 enables both auxiliary outputs together; clear keeps them disabled.
// - sync enable with normal sync: low sync pin holds modulator and filter reset.
// - alternate sync, several channels: low sync at channel switch delays next conversion.
// - error mode 0 disables pin; 1 makes it input ORed inverted into error flag.
// - error mode 2 drives inverted OR of status errors as open drain.
// - error mode 3 drives the error data bit with active pull-up.
// - error data bit sets pin level as output, reads pin state as input.
// - bits 7 and 6 are write-only levels for auxiliary outputs b and a.
// - bits 5 and 4 make bidirectional pins 1 and 0 inputs.
// - bits 3 and 2 make bidirectional pins 1 and 0 outputs unless bits 5 and 4 are also set.
// - bit 1 drives bidirectional pin 1 as output, reads its level as input.
// - ready bit goes low when a new or calibration result is written.
// - integrity check flags a register error on any change while enabled.
// - bit 0 drives bidirectional pin 0 as output, reads its level as input.
`ifndef ARC_CONSTS_VH
`define ARC_CONSTS_VH
`define ARC_ADDR_STATUS 6'h00
`define ARC_ADDR_IFMODE 6'h02
`define ARC_ADDR_CHECK 6'h03
`define ARC_ADDR_DATA 6'h04
`define ARC_ADDR_GPIO 6'h06
`define ARC_IFM_RST 16'h0000
`define ARC_IFM_MASK 16'h11ED
`define ARC_GPIO_RST 16'h0800
`define ARC_GPIO_MASK 16'h7FFF
`define ARC_IFM_ALTSYNC 12
`define ARC_IFM_DATASTAT 6
`define ARC_IFM_INTEGRITY 5
`define ARC_IFM_SHORTWORD 0
`define ARC_GP_PWRSWITCH 14
`define ARC_GP_AUXEN 13
`define ARC_GP_SYNCEN 11
`define ARC_GP_ERRMODE_HI 10
`define ARC_GP_ERRMODE_LO 9
`define ARC_GP_ERRDAT 8
`define ARC_GP_AUXB 7
`define ARC_GP_AUXA 6
`define ARC_GP_IPEN1 5
`define ARC_GP_IPEN0 4
`define ARC_GP_OPEN1 3
`define ARC_GP_OPEN0 2
`define ARC_GP_DAT1 1
`define ARC_GP_DAT0 0
`define ARC_ERR_OFF 2'h0
`define ARC_ERR_IN 2'h1
`define ARC_ERR_OD 2'h2
`define ARC_ERR_OUT 2'h3
`define ARC_LEN_8 6'h08
`define ARC_LEN_16 6'h10
`define ARC_LEN_24 6'h18
`define ARC_LEN_32 6'h20
`define ARC_CMD_LAST 6'h07
`define ARC_WR_LAST 6'h0F
`define ARC_OB_FLIP 24'h800000
`endif

/* rtl/arc_result_regs.v */
`timescale 1ns/1ps
`include "arc_consts.vh"
module arc_result_regs #(
    parameter [23:0] TRIM_WORD = 24'h5A5A5A // arbitrary value
) (
    input wire clock,
    input wire reset_n,
    input wire spiSclk,
    input wire spiCsN,
    input wire spiDin,
    output reg spiDout,
    input wire resultValid,
    input wire [23:0] resultRaw,
    input wire [3:0] resultChannel,
    input wire resultOverRange,
    input wire codingSelect,
    input wire multiChannel,
    input wire channelSwitchDue,
    input wire [23:0] otherRegsXor,
    input wire syncPin,
    output reg modulatorReset,
    output reg conversionHold,
    output reg readyN,
    output reg powerDownSwitchEnable,
    output reg auxOutputsEnable,
    output reg auxOutputAPin,
    output reg auxOutputBPin,
    input wire bidirPin0In,
    output reg bidirPin0Out,
    output reg bidirPin0Oe,
    input wire bidirPin1In,
    output reg bidirPin1Out,
    output reg bidirPin1Oe,
    input wire errorPinIn,
    output reg errorPinOut,
    output reg errorPinOe
);

////////////////////////////////////////////////////////////////////////////////
// serial phases
localparam [2:0] PH_CMD = 3'b001;
localparam [2:0] PH_RD = 3'b010;
localparam [2:0] PH_WR = 3'b100;

// pin synchronisers: {err, gp1, gp0, sync, din, cs, sclk}
reg [6:0] meta_q;
reg [6:0] pin_q;
reg sclkOld_q;

reg [2:0] phase_q;
reg [5:0] cnt_q;
reg [5:0] len_q;
reg [5:0] addr_q;
reg [31:0] sh_q;
reg dataReading_q;

reg [15:0] ifm_q;
reg [15:0] gp_q;
reg [23:0] data_q;
reg dataShort_q;
reg [3:0] chan_q;
reg overRange_q;
reg regError_q;
reg [23:0] snap_q;
reg regCheckOld_q;

reg pend_q;
reg [23:0] pendRaw_q;
reg [3:0] pendChan_q;
reg pendOver_q;

wire sclkS = pin_q[0];
wire csS = pin_q[1];
wire dinS = pin_q[2];
wire syncS = pin_q[3];
wire gp0S = pin_q[4];
wire gp1S = pin_q[5];
wire errS = pin_q[6];
wire sclkRise = sclkS & ~sclkOld_q;

wire [1:0] errMode = gp_q[`ARC_GP_ERRMODE_HI:`ARC_GP_ERRMODE_LO];
wire register_integrity_checksum = ifm_q[`ARC_IFM_INTEGRITY];
wire [7:0] cmdByte = {sh_q[6:0], dinS};
wire [15:0] wrWord = {sh_q[14:0], dinS};

////////////////////////////////////////////////////////////////////////////////
// status, checksum and readback
wire adcError = overRange_q | (errMode == `ARC_ERR_IN & ~errS);
wire [7:0] statusByte = {readyN, adcError, 1'b0, regError_q, chan_q};
wire [23:0] liveSum = otherRegsXor ^ TRIM_WORD ^ {8'h00, gp_q};
wire [23:0] checkRead = register_integrity_checksum ? liveSum : 24'h000000;

reg [15:0] gpRead;
always @* begin
    gpRead = gp_q;
    gpRead[`ARC_GP_AUXB] = 1'b0;
    gpRead[`ARC_GP_AUXA] = 1'b0;
    if (errMode == `ARC_ERR_IN) begin
        gpRead[`ARC_GP_ERRDAT] = errS;
    end
    if (gp_q[`ARC_GP_IPEN1]) begin
        gpRead[`ARC_GP_DAT1] = gp1S;
    end
    if (gp_q[`ARC_GP_IPEN0]) begin
        gpRead[`ARC_GP_DAT0] = gp0S;
    end
end

// read word is left aligned so the shifter always sends bit 31 first
reg [31:0] rdWord;
reg [5:0] rdLen;
always @* begin
    rdWord = 32'h00000000;
    rdLen = `ARC_LEN_8;
    if (cmdByte[5:0] == `ARC_ADDR_STATUS) begin
        rdWord = {statusByte, 24'h000000};
    end else if (cmdByte[5:0] == `ARC_ADDR_IFMODE) begin
        rdWord = {ifm_q, 16'h0000};
        rdLen = `ARC_LEN_16;
    end else if (cmdByte[5:0] == `ARC_ADDR_CHECK) begin
        rdWord = {checkRead, 8'h00};
        rdLen = `ARC_LEN_24;
    end else if (cmdByte[5:0] == `ARC_ADDR_DATA) begin
        if (dataShort_q) begin
            rdWord = {data_q[15:0], statusByte, 8'h00};
            rdLen = ifm_q[`ARC_IFM_DATASTAT] ? `ARC_LEN_24 : `ARC_LEN_16;
        end else begin
            rdWord = {data_q, statusByte};
            rdLen = ifm_q[`ARC_IFM_DATASTAT] ? `ARC_LEN_32 : `ARC_LEN_24;
        end
    end else if (cmdByte[5:0] == `ARC_ADDR_GPIO) begin
        rdWord = {gpRead, 16'h0000};
        rdLen = `ARC_LEN_16;
    end
end

wire cmdDone = ~csS & sclkRise & phase_q[0] & (cnt_q == `ARC_CMD_LAST);
wire startDataRead = cmdDone & ~cmdByte[7] & cmdByte[6] & (cmdByte[5:0] == `ARC_ADDR_DATA);
wire wrDone = ~csS & sclkRise & phase_q[2] & (cnt_q == `ARC_WR_LAST);

// a result arriving during a data read waits in the pending slot
wire commitNow = pend_q & ~dataReading_q & ~startDataRead;

// coding and word length are applied when the result is committed
wire [23:0] offsetBin = pendRaw_q ^ `ARC_OB_FLIP;
wire [23:0] unipolar = pendRaw_q[23] ? 24'h000000 : {pendRaw_q[22:0], 1'b0};
wire [23:0] coded = codingSelect ? offsetBin : unipolar;

////////////////////////////////////////////////////////////////////////////////
// clocked logic
always @(posedge clock) begin
    if (!reset_n) begin
        // idle levels: sclk, cs and sync high, so release brings no false edge or sync reset pulse
        meta_q <= 7'h0B;
        pin_q <= 7'h0B;
        sclkOld_q <= 1'b1;
        phase_q <= PH_CMD;
        cnt_q <= 6'h00;
        len_q <= 6'h00;
        addr_q <= 6'h00;
        sh_q <= 32'h00000000;
        dataReading_q <= 1'b0;
        ifm_q <= `ARC_IFM_RST;
        gp_q <= `ARC_GPIO_RST;
        data_q <= 24'h000000;
        dataShort_q <= 1'b0;
        chan_q <= 4'h0;
        overRange_q <= 1'b0;
        regError_q <= 1'b0;
        snap_q <= 24'h000000;
        regCheckOld_q <= 1'b0;
        pend_q <= 1'b0;
        pendRaw_q <= 24'h000000;
        pendChan_q <= 4'h0;
        pendOver_q <= 1'b0;
        readyN <= 1'b1;
        spiDout <= 1'b1;
        modulatorReset <= 1'b0;
        conversionHold <= 1'b0;
        powerDownSwitchEnable <= 1'b0;
        auxOutputsEnable <= 1'b0;
        auxOutputAPin <= 1'b0;
        auxOutputBPin <= 1'b0;
        bidirPin0Out <= 1'b0;
        bidirPin0Oe <= 1'b0;
        bidirPin1Out <= 1'b0;
        bidirPin1Oe <= 1'b0;
        errorPinOut <= 1'b0;
        errorPinOe <= 1'b0;
    end else begin
        meta_q <= {errorPinIn, bidirPin1In, bidirPin0In, syncPin, spiDin, spiCsN, spiSclk};
        pin_q <= meta_q;
        sclkOld_q <= sclkS;

        // serial engine: mode 3, host samples on rising edge, device shifts after it
        if (csS) begin
            phase_q <= PH_CMD;
            cnt_q <= 6'h00;
            dataReading_q <= 1'b0;
        end else if (sclkRise) begin
            case (phase_q)
                PH_CMD: begin
                    sh_q <= {sh_q[30:0], dinS};
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == `ARC_CMD_LAST) begin
                        cnt_q <= 6'h00;
                        addr_q <= cmdByte[5:0];
                        // a set top bit is not a valid command byte
                        if (!cmdByte[7] && cmdByte[6]) begin
                            phase_q <= PH_RD;
                            sh_q <= rdWord;
                            len_q <= rdLen;
                            dataReading_q <= startDataRead;
                        end else if (!cmdByte[7]) begin
                            phase_q <= PH_WR;
                        end
                    end
                end
                PH_RD: begin
                    sh_q <= {sh_q[30:0], 1'b0};
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == len_q - 6'h01) begin
                        phase_q <= PH_CMD;
                        cnt_q <= 6'h00;
                        dataReading_q <= 1'b0;
                    end
                end
                PH_WR: begin
                    sh_q <= {sh_q[30:0], dinS};
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == `ARC_WR_LAST) begin
                        phase_q <= PH_CMD;
                        cnt_q <= 6'h00;
                    end
                end
                default: begin
                    phase_q <= PH_CMD;
                    cnt_q <= 6'h00;
                end
            endcase
        end

        // register writes; ifmode write leaves the converter and held data alone
        if (wrDone && addr_q == `ARC_ADDR_IFMODE) begin
            ifm_q <= wrWord & `ARC_IFM_MASK;
        end
        if (wrDone && addr_q == `ARC_ADDR_GPIO) begin
            gp_q <= wrWord & `ARC_GPIO_MASK;
        end

        // result path
        if (commitNow) begin
            pend_q <= 1'b0;
            dataShort_q <= ifm_q[`ARC_IFM_SHORTWORD];
            data_q <= ifm_q[`ARC_IFM_SHORTWORD] ? {8'h00, coded[23:8]} : coded;
            chan_q <= pendChan_q;
            overRange_q <= pendOver_q;
        end
        if (resultValid) begin
            pend_q <= 1'b1;
            pendRaw_q <= resultRaw;
            pendChan_q <= resultChannel;
            pendOver_q <= resultOverRange;
        end
        // data stays in place after a read so it can be read again
        if (commitNow) begin
            readyN <= 1'b0;
        end else if (startDataRead) begin
            readyN <= 1'b1;
        end

        // integrity check: snapshot on enable, flag any later change
        regCheckOld_q <= register_integrity_checksum;
        if (register_integrity_checksum && !regCheckOld_q) begin
            snap_q <= liveSum;
        end
        if (!register_integrity_checksum) begin
            regError_q <= 1'b0;
        end else if (regCheckOld_q && liveSum != snap_q) begin
            regError_q <= 1'b1;
        end

        // ready shows on the data pin while selected and no read is shifting; deselected it is held high
        if (csS) begin
            spiDout <= 1'b1;
        end else if (phase_q == PH_RD) begin
            spiDout <= sh_q[31];
        end else begin
            spiDout <= readyN;
        end

        // sync: alternate mode only takes effect with several channels
        if (gp_q[`ARC_GP_SYNCEN] && ifm_q[`ARC_IFM_ALTSYNC] && multiChannel) begin
            modulatorReset <= 1'b0;
            if (syncS) begin
                conversionHold <= 1'b0;
            end else if (channelSwitchDue) begin
                conversionHold <= 1'b1;
            end
        end else begin
            modulatorReset <= gp_q[`ARC_GP_SYNCEN] & ~syncS;
            conversionHold <= 1'b0;
        end

        powerDownSwitchEnable <= gp_q[`ARC_GP_PWRSWITCH];
        auxOutputsEnable <= gp_q[`ARC_GP_AUXEN];
        auxOutputAPin <= gp_q[`ARC_GP_AUXEN] & gp_q[`ARC_GP_AUXA];
        auxOutputBPin <= gp_q[`ARC_GP_AUXEN] & gp_q[`ARC_GP_AUXB];
        bidirPin0Oe <= gp_q[`ARC_GP_OPEN0] & ~gp_q[`ARC_GP_IPEN0];
        bidirPin1Oe <= gp_q[`ARC_GP_OPEN1] & ~gp_q[`ARC_GP_IPEN1];
        bidirPin0Out <= gp_q[`ARC_GP_DAT0];
        bidirPin1Out <= gp_q[`ARC_GP_DAT1];

        case (errMode)
            `ARC_ERR_OD: begin
                errorPinOut <= 1'b0;
                errorPinOe <= adcError | regError_q;
            end
            `ARC_ERR_OUT: begin
                errorPinOut <= gp_q[`ARC_GP_ERRDAT];
                errorPinOe <= 1'b1;
            end
            default: begin
                errorPinOut <= 1'b0;
                errorPinOe <= 1'b0;
            end
        endcase
    end
end

endmodule

/* bench/arc_result_regs_props.sv */
`timescale 1ns/1ps
module arc_result_regs_props (
    input wire clock,
    input wire reset_n,
    input wire spiCsN,
    input wire spiDout,
    input wire resultValid,
    input wire syncPin,
    input wire modulatorReset,
    input wire conversionHold,
    input wire readyN,
    input wire powerDownSwitchEnable,
    input wire auxOutputsEnable,
    input wire auxOutputAPin,
    input wire auxOutputBPin,
    input wire bidirPin0Oe
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // six cycles covers the two-flop synchroniser plus the registered output
    sequence s_bus_quiet;
        spiCsN [*6];
    endsequence
    sequence s_sync_high;
        syncPin [*6];
    endsequence
    a_cs_idle_high: assert property (s_bus_quiet |-> spiDout) else $error("data out low while deselected");
    a_result_commit: assert property (s_bus_quiet ##0 resultValid |-> ##2 !readyN) else $error("no ready");
    a_ready_by_read: assert property ($rose(readyN) |-> !$past(spiCsN, 2)) else $error("ready rose idle");
    a_cfg_by_write: assert property (($changed(powerDownSwitchEnable) || $changed(auxOutputsEnable)
        || $changed(bidirPin0Oe)) |-> !$past(spiCsN, 2)) else $error("pin config moved idle");
    a_sync_reset_cause: assert property (modulatorReset |-> (!$past(syncPin, 3) || !$past(syncPin, 4)))
        else $error("reset without low sync");
    a_sync_release: assert property (s_sync_high |-> !modulatorReset) else $error("reset held");
    a_hold_release: assert property (s_sync_high |-> !conversionHold) else $error("hold stuck");
    a_aux_a_gate: assert property (auxOutputAPin |-> auxOutputsEnable) else $error("aux a ungated");
    a_aux_b_gate: assert property (auxOutputBPin |-> auxOutputsEnable) else $error("aux b ungated");
endmodule
bind arc_result_regs arc_result_regs_props arc_result_regs_props_inst (.clock(clock), .reset_n(reset_n),
    .spiCsN(spiCsN), .spiDout(spiDout), .resultValid(resultValid), .syncPin(syncPin),
    .modulatorReset(modulatorReset), .conversionHold(conversionHold), .readyN(readyN),
    .powerDownSwitchEnable(powerDownSwitchEnable), .auxOutputsEnable(auxOutputsEnable),
    .auxOutputAPin(auxOutputAPin), .auxOutputBPin(auxOutputBPin), .bidirPin0Oe(bidirPin0Oe));

/* bench/arc_host_model.sv */
`timescale 1ns/1ps
module arc_host_model (
    input wire clock,
    input wire spiDout,
    output reg spiSclk,
    output reg spiCsN,
    output reg spiDin
);
    // half period well above the two-cycle minimum of the synchroniser
    localparam integer HALF = 6;
    initial begin
        spiSclk = 1'b1;
        spiCsN = 1'b1;
        spiDin = 1'b0;
    end
    task waitc(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask
    task bitx(input b, output s);
        begin
            spiSclk = 1'b0;
            spiDin = b;
            waitc(HALF);
            spiSclk = 1'b1;
            s = spiDout;
            waitc(HALF);
        end
    endtask
    task xfer(input [7:0] cmd, input [31:0] wd, input integer n, output [31:0] rd);
        integer i;
        reg s;
        begin
            rd = 32'h0;
            spiCsN = 1'b0;
            waitc(HALF);
            for (i = 7; i >= 0; i = i - 1) bitx(cmd[i], s);
            for (i = n - 1; i >= 0; i = i - 1) begin
                bitx(wd[i], s);
                rd = {rd[30:0], s};
            end
            spiCsN = 1'b1;
            // a released line must not keep showing the last bit
            spiDin = ~spiDin;
            waitc(HALF);
        end
    endtask
endmodule

/* bench/arc_result_regs_tb_top.sv */
`timescale 1ns/1ps
module arc_result_regs_tb_top;
    localparam [23:0] TRIM = 24'h5A5A5A; // arbitrary value
    reg clock, reset_n, resultValid, resultOverRange, codingSelect, multiChannel, channelSwitchDue, syncPin;
    reg [23:0] resultRaw, otherRegsXor;
    reg [3:0] resultChannel;
    reg ext0, ext1, errExt;
    reg [31:0] rd;
    integer badCount, checksDone;
    wire spiSclk, spiCsN, spiDin, spiDout, modRst, convHold, readyN, power_down_switch_enable, auxEn, auxA, auxB;
    wire out0, oe0, out1, oe1, errOut, errOe;
    wire pin0 = oe0 ? out0 : ext0;
    wire pin1 = oe1 ? out1 : ext1;
    wire errPin = errOe ? errOut : errExt;
    arc_result_regs #(.TRIM_WORD(TRIM)) arc_result_regs_inst (.clock(clock), .reset_n(reset_n),
        .spiSclk(spiSclk), .spiCsN(spiCsN), .spiDin(spiDin), .spiDout(spiDout), .resultValid(resultValid),
        .resultRaw(resultRaw), .resultChannel(resultChannel), .resultOverRange(resultOverRange),
        .codingSelect(codingSelect), .multiChannel(multiChannel), .channelSwitchDue(channelSwitchDue),
        .otherRegsXor(otherRegsXor), .syncPin(syncPin), .modulatorReset(modRst), .conversionHold(convHold),
        .readyN(readyN), .powerDownSwitchEnable(power_down_switch_enable), .auxOutputsEnable(auxEn), .auxOutputAPin(auxA),
        .auxOutputBPin(auxB), .bidirPin0In(pin0), .bidirPin0Out(out0), .bidirPin0Oe(oe0), .bidirPin1In(pin1),
        .bidirPin1Out(out1), .bidirPin1Oe(oe1), .errorPinIn(errPin), .errorPinOut(errOut), .errorPinOe(errOe));
    arc_host_model host_inst (.clock(clock), .spiDout(spiDout), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiDin(spiDin));
    ////////////////////////////////////////////////////////////////////////////////
    task tick(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checksDone = checksDone + 1;
            if (got !== exp) begin
                $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
                badCount = badCount + 1;
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        host_inst.xfer(a, {16'h0, d}, 16, rd);
    endtask
    task rdr(input [7:0] a, input integer n);
        host_inst.xfer(8'h40 | a, 32'h0, n, rd);
    endtask
    task post(input [23:0] raw, input [3:0] ch, input ovr);
        begin
            resultRaw = raw;
            resultChannel = ch;
            resultOverRange = ovr;
            resultValid = 1'b1;
            tick(1);
            resultValid = 1'b0;
            tick(2);
        end
    endtask
    task completeRun;
        begin
            if (badCount == 0 && checksDone > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task tReset;
        begin
            chk({readyN, spiDout}, 2'b11);
            rdr(8'h06, 16);
            chk(rd, 32'h0800);
            rdr(8'h03, 24);
            chk(rd, 32'h0);
            rdr(8'h07, 8);
            chk(rd, 32'h0);
        end
    endtask
    task tResult;
        begin
            post(24'h123456, 4'h1, 1'b0);
            chk(readyN, 1'b0);
            rdr(8'h04, 24);
            chk(rd, 32'h923456);
            chk(readyN, 1'b1);
            rdr(8'h04, 24);
            chk(rd, 32'h923456);
            wr(8'h02, 16'h0001);
            rdr(8'h04, 24);
            chk(rd, 32'h923456);
            codingSelect = 1'b0;
            post(24'h000100, 4'h1, 1'b0);
            rdr(8'h04, 16);
            chk(rd, 32'h0002);
            codingSelect = 1'b1;
            wr(8'h02, 16'h0040);
            post(24'hFFFFFF, 4'h5, 1'b0);
            rdr(8'h04, 32);
            chk({rd[31:8], 1'b0, rd[6:0]}, 32'h7FFFFF05);
            wr(8'h02, 16'h0000);
        end
    endtask
    task tInterlock;
        begin
            post(24'h000010, 4'h0, 1'b0);
            fork
                rdr(8'h04, 24);
                begin
                    tick(150);
                    post(24'h000020, 4'h0, 1'b0);
                end
            join
            chk(rd, 32'h800010);
            chk(readyN, 1'b0);
            rdr(8'h04, 24);
            chk(rd, 32'h800020);
        end
    endtask
    task tCheck;
        begin
            wr(8'h02, 16'h0020);
            rdr(8'h03, 24);
            chk(rd, {8'h0, 24'h0F0F0F ^ TRIM ^ 24'h000800});
            otherRegsXor = 24'h0F0F0E;
            tick(3);
            rdr(8'h00, 8);
            chk(rd[4], 1'b1);
            wr(8'h02, 16'h0000);
            rdr(8'h03, 24);
            chk(rd, 32'h0);
        end
    endtask
    task tPins;
        begin
            wr(8'h06, 16'h60CD);
            tick(3);
            chk({power_down_switch_enable, auxEn, auxA, auxB, oe0, out0, oe1, out1}, 8'hFE);
            rdr(8'h06, 16);
            chk(rd, 32'h600D);
            wr(8'h06, 16'h023C);
            tick(3);
            chk({oe0, oe1, errOe, power_down_switch_enable, auxEn, auxA, auxB}, 7'h0);
            rdr(8'h06, 16);
            chk(rd, 32'h023E);
            rdr(8'h00, 8);
            chk(rd[6], 1'b1);
            wr(8'h06, 16'h0700);
            tick(3);
            chk({errOe, errOut}, 2'b11);
            wr(8'h06, 16'h0400);
            post(24'h0, 4'h0, 1'b1);
            chk({errOe, errOut}, 2'b10);
            post(24'h0, 4'h0, 1'b0);
            wr(8'h06, 16'h0000);
            tick(3);
            chk(errOe, 1'b0);
        end
    endtask
    task tSync;
        begin
            wr(8'h06, 16'h0800);
            syncPin = 1'b0;
            tick(6);
            chk(modRst, 1'b1);
            syncPin = 1'b1;
            tick(6);
            chk(modRst, 1'b0);
            wr(8'h02, 16'h1000);
            multiChannel = 1'b1;
            syncPin = 1'b0;
            tick(6);
            chk(modRst, 1'b0);
            channelSwitchDue = 1'b1;
            tick(1);
            channelSwitchDue = 1'b0;
            tick(3);
            chk(convHold, 1'b1);
            syncPin = 1'b1;
            tick(6);
            chk(convHold, 1'b0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        tick(60000);
        badCount = badCount + 1;
        completeRun;
    end
    initial begin
        {reset_n, resultValid, resultOverRange, multiChannel, channelSwitchDue} = 5'h0;
        {codingSelect, syncPin, ext1, ext0, errExt} = 5'h1C;
        resultRaw = 24'h0;
        resultChannel = 4'h0;
        otherRegsXor = 24'h0F0F0F;
        badCount = 0;
        checksDone = 0;
        tick(10);
        reset_n = 1'b1;
        tick(3);
        tReset;
        tResult;
        tInterlock;
        tCheck;
        tPins;
        tSync;
        completeRun;
    end
endmodule
